// file: rtl/srpr_read_param.sv
`timescale 1ns/1ns
`default_nettype none
`include "srpr_params.svh"

module srpr_read_param #(
   parameter int REG_W = `SRPR_REG_W
) (
   // Clock and reset
   input  wire logic                     i_clk,
   input  wire logic                     i_sys_rst,
   // Serial link pins
   input  wire logic                     i_sck,
   input  wire logic                     i_cs_n,
   input  wire logic [3:0]               i_io,
   // Device mode from the surrounding logic
   input  wire logic                     i_quad_lines_enable_bit,
   input  wire logic                     i_four_line_command_mode,
   input  wire logic                     i_dedicated_reset_present,
   input  wire logic                     i_dedicated_reset_disable,
   input  wire srpr_pkg::srpr_read_kind_e i_read_kind,
   // Register contents
   output logic [REG_W-1:0]              o_working_value,
   output logic [REG_W-1:0]              o_persistent_value,
   output logic                          o_boot_done,
   // Pin roles
   output logic                          o_shared_pin_is_reset,
   output logic                          o_shared_pin_is_pause,
   output logic                          o_shared_pin_is_data,
   output logic                          o_wp_pin_is_data,
   // Read behaviour
   output logic [3:0]                    o_dummy_cycles,
   output logic                          o_wrap_in_burst,
   output logic [6:0]                    o_wrap_bytes
);

   if (REG_W != 8) begin : g_check
      $error("srpr_read_param supports an 8-bit register only");
   end

   logic       frame_active;
   logic       byte_valid;
   logic       byte_first;
   logic [7:0] rx_byte;

   srpr_link_rx #(
      .BYTE_W (8)
   ) u_link_rx (
      .i_clk          (i_clk),
      .i_sys_rst      (i_sys_rst),
      .i_sck          (i_sck),
      .i_cs_n         (i_cs_n),
      .i_io           (i_io),
      .i_four_line    (i_four_line_command_mode),
      .o_frame_active (frame_active),
      .o_byte_valid   (byte_valid),
      .o_byte_first   (byte_first),
      .o_byte         (rx_byte)
   );

   function automatic logic [3:0] dummy_for(input srpr_pkg::srpr_read_kind_e kind,
                                            input logic [3:0] field);
      logic [3:0] dflt;
      dflt = `SRPR_DUMMY_DEF_EIGHT;
      unique case (kind)
         srpr_pkg::SRPR_RD_FAST_SINGLE,
         srpr_pkg::SRPR_RD_DUAL_OUT,
         srpr_pkg::SRPR_RD_QUAD_OUT,
         srpr_pkg::SRPR_RD_FAST_DOUBLE_EDGE: dflt = `SRPR_DUMMY_DEF_EIGHT;
         srpr_pkg::SRPR_RD_FAST_FOUR_LINE,
         srpr_pkg::SRPR_RD_QUAD_IO,
         srpr_pkg::SRPR_RD_QUAD_DOUBLE_EDGE: dflt = `SRPR_DUMMY_DEF_SIX;
         srpr_pkg::SRPR_RD_DUAL_IO:          dflt = `SRPR_DUMMY_DEF_FOUR;
      endcase
      // Double-edge four-line reads use the same default as the single-edge form.
      if (kind == srpr_pkg::SRPR_RD_FAST_DOUBLE_EDGE && i_four_line_command_mode) begin
         dflt = `SRPR_DUMMY_DEF_SIX;
      end
      return (field == 4'h0) ? dflt : field;
   endfunction

   function automatic logic [6:0] wrap_bytes_for(input logic [1:0] code);
      return 7'(`SRPR_WRAP_BASE_BYTES << code);
   endfunction

   // Command decode and register update.
   srpr_pkg::srpr_state_e  state_q, state_d;
   srpr_pkg::srpr_target_e target_q, target_d;
   logic [7:0] work_q, work_d;
   logic [7:0] pers_q, pers_d;

   always_comb begin
      state_d  = state_q;
      target_d = target_q;
      work_d   = work_q;
      pers_d   = pers_q;
      unique case (state_q)
         srpr_pkg::SRPR_ST_BOOT: begin
            work_d  = pers_q;
            state_d = srpr_pkg::SRPR_ST_CMD;
         end
         srpr_pkg::SRPR_ST_CMD: begin
            if (byte_valid && byte_first) begin
               if (rx_byte == `SRPR_CMD_SET_PERSISTENT) begin
                  target_d = srpr_pkg::SRPR_TGT_PERSISTENT;
                  state_d  = srpr_pkg::SRPR_ST_DATA;
               end else if (rx_byte == `SRPR_CMD_SET_WORKING_A ||
                            rx_byte == `SRPR_CMD_SET_WORKING_B) begin
                  target_d = srpr_pkg::SRPR_TGT_WORKING;
                  state_d  = srpr_pkg::SRPR_ST_DATA;
               end else begin
                  state_d  = srpr_pkg::SRPR_ST_SKIP;
               end
            end
         end
         srpr_pkg::SRPR_ST_DATA: begin
            if (!frame_active) begin
               target_d = srpr_pkg::SRPR_TGT_NONE;
               state_d  = srpr_pkg::SRPR_ST_CMD;
            end else if (byte_valid) begin
               // Each copy is written alone; the other keeps its value.
               if (target_q == srpr_pkg::SRPR_TGT_PERSISTENT) begin
                  pers_d = rx_byte;
               end else begin
                  work_d = rx_byte;
               end
               target_d = srpr_pkg::SRPR_TGT_NONE;
               state_d  = srpr_pkg::SRPR_ST_SKIP;
            end
         end
         srpr_pkg::SRPR_ST_SKIP: begin
            // Extra bytes after the data byte are ignored until the frame ends.
            if (!frame_active) begin
               state_d = srpr_pkg::SRPR_ST_CMD;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q  <= srpr_pkg::SRPR_ST_BOOT;
         target_q <= srpr_pkg::SRPR_TGT_NONE;
         work_q   <= `SRPR_RESET_VALUE;
         pers_q   <= `SRPR_NV_RESET_VALUE;
      end else begin
         state_q  <= state_d;
         target_q <= target_d;
         work_q   <= work_d;
         pers_q   <= pers_d;
      end
   end

   // Registered view of the behaviour the working copy selects.
   logic       reset_role_q, reset_role_d;
   logic       pause_role_q, pause_role_d;
   logic       data_role_q, data_role_d;
   logic [3:0] dummy_q, dummy_d;
   logic       wrap_q, wrap_d;
   logic [6:0] wrap_bytes_q, wrap_bytes_d;
   logic       boot_done_q, boot_done_d;

   always_comb begin
      // Four-line mode always drives all four lanes, so it frees the control pins too.
      data_role_d  = i_quad_lines_enable_bit | i_four_line_command_mode;
      reset_role_d = 1'b0;
      pause_role_d = 1'b0;
      if (!data_role_d) begin
         if (i_dedicated_reset_present && !i_dedicated_reset_disable) begin
            pause_role_d = 1'b1;
         end else begin
            reset_role_d = work_q[`SRPR_PIN_ROLE_BIT];
            pause_role_d = ~work_q[`SRPR_PIN_ROLE_BIT];
         end
      end
      dummy_d      = dummy_for(i_read_kind, work_q[`SRPR_DUMMY_MSB:`SRPR_DUMMY_LSB]);
      wrap_d       = work_q[`SRPR_WRAP_EN_BIT];
      // Zero wrap size means the whole array when wrapping is off.
      wrap_bytes_d = wrap_d ? wrap_bytes_for(work_q[`SRPR_BURST_MSB:`SRPR_BURST_LSB])
                            : 7'h00;
      boot_done_d  = (state_q != srpr_pkg::SRPR_ST_BOOT);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         reset_role_q <= 1'b0;
         pause_role_q <= 1'b1;
         data_role_q  <= 1'b0;
         dummy_q      <= `SRPR_DUMMY_DEF_EIGHT;
         wrap_q       <= 1'b0;
         wrap_bytes_q <= 7'h00;
         boot_done_q  <= 1'b0;
      end else begin
         reset_role_q <= reset_role_d;
         pause_role_q <= pause_role_d;
         data_role_q  <= data_role_d;
         dummy_q      <= dummy_d;
         wrap_q       <= wrap_d;
         wrap_bytes_q <= wrap_bytes_d;
         boot_done_q  <= boot_done_d;
      end
   end

   assign o_working_value       = work_q;
   assign o_persistent_value    = pers_q;
   assign o_boot_done           = boot_done_q;
   assign o_shared_pin_is_reset = reset_role_q;
   assign o_shared_pin_is_pause = pause_role_q;
   assign o_shared_pin_is_data  = data_role_q;
   assign o_wp_pin_is_data      = data_role_q;
   assign o_dummy_cycles        = dummy_q;
   assign o_wrap_in_burst       = wrap_q;
   assign o_wrap_bytes          = wrap_bytes_q;

endmodule

`default_nettype wire

// file: rtl/srpr_params.svh
`ifndef SRPR_PARAMS_SVH
`define SRPR_PARAMS_SVH

// Read-parameter register layout.
`define SRPR_REG_W          8
`define SRPR_RESET_VALUE    8'h00
`define SRPR_NV_RESET_VALUE 8'h00
`define SRPR_PIN_ROLE_BIT   7
`define SRPR_DUMMY_MSB      6
`define SRPR_DUMMY_LSB      3
`define SRPR_WRAP_EN_BIT    2
`define SRPR_BURST_MSB      1
`define SRPR_BURST_LSB      0

// Command codes of the two set-parameter operations.
`define SRPR_CMD_SET_PERSISTENT 8'h65
`define SRPR_CMD_SET_WORKING_A  8'hc0
`define SRPR_CMD_SET_WORKING_B  8'h63

// Per-command dummy counts used when the dummy field is zero.
`define SRPR_DUMMY_DEF_EIGHT 4'h8
`define SRPR_DUMMY_DEF_SIX   4'h6
`define SRPR_DUMMY_DEF_FOUR  4'h4

// Smallest wrap boundary in bytes; each burst code step doubles it.
`define SRPR_WRAP_BASE_BYTES 7'h08

`endif

// file: rtl/srpr_pkg.sv
`default_nettype none
package srpr_pkg;

   // Class of the read command being served, which picks the default dummy count.
   typedef enum logic [2:0] {
      SRPR_RD_FAST_SINGLE,
      SRPR_RD_FAST_FOUR_LINE,
      SRPR_RD_DUAL_OUT,
      SRPR_RD_QUAD_OUT,
      SRPR_RD_DUAL_IO,
      SRPR_RD_QUAD_IO,
      SRPR_RD_FAST_DOUBLE_EDGE,
      SRPR_RD_QUAD_DOUBLE_EDGE
   } srpr_read_kind_e;

   // Pending write target of a set-parameter command.
   typedef enum logic [1:0] {
      SRPR_TGT_NONE,
      SRPR_TGT_PERSISTENT,
      SRPR_TGT_WORKING
   } srpr_target_e;

   typedef enum logic [1:0] {
      SRPR_ST_BOOT,
      SRPR_ST_CMD,
      SRPR_ST_DATA,
      SRPR_ST_SKIP
   } srpr_state_e;

endpackage

`default_nettype wire

// file: rtl/srpr_link_rx.sv
`timescale 1ns/1ns
`default_nettype none
`include "srpr_params.svh"

module srpr_link_rx #(
   parameter int BYTE_W = 8
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // Link pins
   input  wire logic              i_sck,
   input  wire logic              i_cs_n,
   input  wire logic [3:0]        i_io,
   // Lane mode
   input  wire logic              i_four_line,
   // Received bytes
   output logic                   o_frame_active,
   output logic                   o_byte_valid,
   output logic                   o_byte_first,
   output logic [BYTE_W-1:0]      o_byte
);

   if (BYTE_W != 8) begin : g_check
      $error("srpr_link_rx serves 8-bit bytes only");
   end

   // Two-stage synchronisers; only stage two is read by logic.
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic       sck_prev_q;
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] shift_q, shift_d;
   logic       first_q, first_d;
   logic       valid_q, valid_d;
   logic       vfirst_q, vfirst_d;
   logic [7:0] byte_q, byte_d;

   logic       sck_s;
   logic       cs_n_s;
   logic [3:0] io_s;
   logic       sck_rise;

   assign sck_s    = sync2_q[5];
   assign cs_n_s   = sync2_q[4];
   assign io_s     = sync2_q[3:0];
   assign sck_rise = sck_s & ~sck_prev_q;

   always_comb begin
      bit_cnt_d = bit_cnt_q;
      shift_d   = shift_q;
      first_d   = first_q;
      valid_d   = 1'b0;
      vfirst_d  = vfirst_q;
      byte_d    = byte_q;
      if (cs_n_s) begin
         bit_cnt_d = 3'h0;
         first_d   = 1'b1;
      end else if (sck_rise) begin
         // Four lanes carry a nibble per edge, high nibble first.
         if (i_four_line) begin
            shift_d   = {shift_q[3:0], io_s};
            bit_cnt_d = bit_cnt_q + 3'h4;
         end else begin
            shift_d   = {shift_q[6:0], io_s[0]};
            bit_cnt_d = bit_cnt_q + 3'h1;
         end
         if ((i_four_line && bit_cnt_q == 3'h4) || (!i_four_line && bit_cnt_q == 3'h7)) begin
            valid_d  = 1'b1;
            vfirst_d = first_q;
            byte_d   = shift_d;
            first_d  = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1_q    <= 6'h30;
         sync2_q    <= 6'h30;
         sck_prev_q <= 1'b1;
         bit_cnt_q  <= 3'h0;
         shift_q    <= 8'h00;
         first_q    <= 1'b1;
         valid_q    <= 1'b0;
         vfirst_q   <= 1'b0;
         byte_q     <= 8'h00;
      end else begin
         sync1_q    <= {i_sck, i_cs_n, i_io};
         sync2_q    <= sync1_q;
         sck_prev_q <= sck_s;
         bit_cnt_q  <= bit_cnt_d;
         shift_q    <= shift_d;
         first_q    <= first_d;
         valid_q    <= valid_d;
         vfirst_q   <= vfirst_d;
         byte_q     <= byte_d;
      end
   end

   assign o_frame_active = ~cs_n_s;
   assign o_byte_valid   = valid_q;
   assign o_byte_first   = vfirst_q;
   assign o_byte         = byte_q;

endmodule

`default_nettype wire

// file: tb/srpr_read_param_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module srpr_read_param_asserts #(
   parameter int REG_W = 8
) (
   // Clock and reset
   input wire logic                      i_clk,
   input wire logic                      i_sys_rst,
   // Link and mode inputs
   input wire logic                      i_sck,
   input wire logic                      i_cs_n,
   input wire logic [3:0]                i_io,
   input wire logic                      i_quad_lines_enable_bit,
   input wire logic                      i_four_line_command_mode,
   input wire logic                      i_dedicated_reset_present,
   input wire logic                      i_dedicated_reset_disable,
   input wire srpr_pkg::srpr_read_kind_e i_read_kind,
   // Design outputs
   input wire logic [REG_W-1:0]          o_working_value,
   input wire logic [REG_W-1:0]          o_persistent_value,
   input wire logic                      o_boot_done,
   input wire logic                      o_shared_pin_is_reset,
   input wire logic                      o_shared_pin_is_pause,
   input wire logic                      o_shared_pin_is_data,
   input wire logic                      o_wp_pin_is_data,
   input wire logic [3:0]                o_dummy_cycles,
   input wire logic                      o_wrap_in_burst,
   input wire logic [6:0]                o_wrap_bytes
);
   logic ok_q;
   // Derived outputs trail the working copy by a clock, so compare only after boot has settled.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ok_q <= 1'b0;
      end else begin
         ok_q <= o_boot_done;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_boot_rises: assert property ($fell(i_sys_rst) |-> ##[1:3] o_boot_done)
      else $error("boot flag late");
   a_boot_load: assert property ($fell(i_sys_rst) |->
      ##2 o_working_value == o_persistent_value)
      else $error("working copy not loaded at boot");
   a_roles_onehot: assert property (
      $onehot({o_shared_pin_is_reset, o_shared_pin_is_pause, o_shared_pin_is_data}))
      else $error("shared pin role not unique");
   a_data_role: assert property (ok_q |-> o_shared_pin_is_data ==
      ($past(i_quad_lines_enable_bit) | $past(i_four_line_command_mode)))
      else $error("data role wrong");
   a_wp_role: assert property (o_wp_pin_is_data == o_shared_pin_is_data)
      else $error("wp role differs");
   // The role is judged from working bit 7 and the mode inputs of the previous cycle; the registered data
   // role follows those same inputs with the same one-cycle lag as the reset role.
   a_reset_role: assert property (ok_q |-> o_shared_pin_is_reset ==
      ($past(o_working_value[7]) & !($past(i_dedicated_reset_present)
      & !$past(i_dedicated_reset_disable)) & !$past(i_quad_lines_enable_bit)
      & !$past(i_four_line_command_mode)))
      else $error("reset role wrong");
   a_dummy_field: assert property (ok_q && $past(o_working_value[6:3]) != 4'h0
      |-> o_dummy_cycles == $past(o_working_value[6:3]))
      else $error("dummy count wrong");
   a_dummy_dual: assert property (ok_q && $past(o_working_value[6:3]) == 4'h0
      && $past(i_read_kind) == srpr_pkg::SRPR_RD_DUAL_IO |-> o_dummy_cycles == 4'h4)
      else $error("dual io default wrong");
   a_wrap_size: assert property (ok_q |-> {o_wrap_in_burst, o_wrap_bytes} ==
      {$past(o_working_value[2]),
      $past(o_working_value[2]) ? 7'h08 << $past(o_working_value[1:0]) : 7'h00})
      else $error("wrap size wrong");
   a_one_copy: assert property ($changed(o_persistent_value) |-> $stable(o_working_value))
      else $error("both copies changed");
   c_reset_role: cover property (o_shared_pin_is_reset);
   c_four_write: cover property (i_four_line_command_mode && $changed(o_working_value));
   c_wrap_max: cover property (o_wrap_bytes == 7'h40);
endmodule
bind srpr_read_param srpr_read_param_asserts #(.REG_W(REG_W)) u_asserts (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_io(i_io),
   .i_quad_lines_enable_bit(i_quad_lines_enable_bit),
   .i_four_line_command_mode(i_four_line_command_mode),
   .i_dedicated_reset_present(i_dedicated_reset_present),
   .i_dedicated_reset_disable(i_dedicated_reset_disable), .i_read_kind(i_read_kind),
   .o_working_value(o_working_value), .o_persistent_value(o_persistent_value),
   .o_boot_done(o_boot_done), .o_shared_pin_is_reset(o_shared_pin_is_reset),
   .o_shared_pin_is_pause(o_shared_pin_is_pause), .o_shared_pin_is_data(o_shared_pin_is_data),
   .o_wp_pin_is_data(o_wp_pin_is_data), .o_dummy_cycles(o_dummy_cycles),
   .o_wrap_in_burst(o_wrap_in_burst), .o_wrap_bytes(o_wrap_bytes));
`default_nettype wire

// file: tb/srpr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module srpr_host_model (
   input  wire logic       i_clk,
   input  wire logic       i_go,
   input  wire logic       i_four,
   input  wire logic [7:0] i_cmd,
   input  wire logic [7:0] i_dat,
   input  wire logic [3:0] i_nb,
   output logic            o_sck,
   output logic            o_cs_n,
   output logic [3:0]      o_io,
   output logic            o_done
);
   logic [15:0] w;
   int          n;
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'h0;
      o_done = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_go) begin
            w = {i_cmd, i_dat};
            n = i_four ? (8 + i_nb) / 4 : 8 + i_nb;
            o_cs_n <= 1'b0;
            for (int k = 0; k < n; k++) begin
               o_io <= i_four ? w[15-4*k -: 4] : {~o_io[3:1], w[15-k]};
               // Four clocks per phase keeps the link at 1.25 MHz.
               repeat (4) @(posedge i_clk);
               o_sck <= 1'b1;
               repeat (4) @(posedge i_clk);
               o_sck <= 1'b0;
            end
            repeat (4) @(posedge i_clk);
            o_cs_n <= 1'b1;
            // Released lines carry no pull, so show the inverse rather than a stale value.
            o_io <= ~o_io;
            o_done <= 1'b1;
            while (i_go) @(posedge i_clk);
            o_done <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk, rst, qe, four, rpres, rdis, go;
   logic [7:0] cmd, dat, w, p, c, d;
   logic [3:0] nb;
   srpr_pkg::srpr_read_kind_e kind;
   logic sck, cs_n, done, bd, pr, pp, pd, wd, wib;
   logic [3:0] io, dum;
   logic [7:0] wv, pv;
   logic [6:0] wb;
   int fails, num_checks;
   int unsigned rs = 51930;
   srpr_host_model host (.i_clk(clk), .i_go(go), .i_four(four), .i_cmd(cmd), .i_dat(dat),
      .i_nb(nb), .o_sck(sck), .o_cs_n(cs_n), .o_io(io), .o_done(done));
   srpr_read_param dut (.i_clk(clk), .i_sys_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_io(io),
      .i_quad_lines_enable_bit(qe), .i_four_line_command_mode(four),
      .i_dedicated_reset_present(rpres), .i_dedicated_reset_disable(rdis), .i_read_kind(kind),
      .o_working_value(wv), .o_persistent_value(pv), .o_boot_done(bd),
      .o_shared_pin_is_reset(pr), .o_shared_pin_is_pause(pp), .o_shared_pin_is_data(pd),
      .o_wp_pin_is_data(wd), .o_dummy_cycles(dum), .o_wrap_in_burst(wib), .o_wrap_bytes(wb));
   always #50 clk = ~clk;
   function int unsigned rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function logic [3:0] e_dum(logic [7:0] v);
      if (v[6:3] != 4'h0) return v[6:3];
      case (kind)
         srpr_pkg::SRPR_RD_DUAL_IO: return 4'h4;
         srpr_pkg::SRPR_RD_FAST_FOUR_LINE, srpr_pkg::SRPR_RD_QUAD_IO,
         srpr_pkg::SRPR_RD_QUAD_DOUBLE_EDGE: return 4'h6;
         srpr_pkg::SRPR_RD_FAST_DOUBLE_EDGE: return four ? 4'h6 : 4'h8;
         default: return 4'h8;
      endcase
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_all();
      logic dr, rr;
      dr = qe | four;
      rr = !dr && w[7] && !(rpres && !rdis);
      chk("working", w, wv);
      chk("persistent", p, pv);
      chk("boot", 8'h01, {7'h0, bd});
      chk("roles", {5'h0, dr, rr, !dr && !rr}, {5'h0, pd, pr, pp});
      chk("wp", {7'h0, dr}, {7'h0, wd});
      chk("dummy", {4'h0, e_dum(w)}, {4'h0, dum});
      chk("wrap", {w[2], w[2] ? 7'h08 << w[1:0] : 7'h00}, {wib, wb});
   endtask
   task automatic send(input logic [7:0] sc, input logic [7:0] sd, input logic [3:0] sn);
      int t;
      cmd <= sc;
      dat <= sd;
      nb <= sn;
      go <= 1'b1;
      t = 0;
      while (done !== 1'b1 && t < 1000) begin
         @(posedge clk);
         t++;
      end
      if (t >= 1000) begin
         fails++;
         close_out();
      end
      go <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   initial begin
      {clk, rst, qe, four, rpres, rdis, go} = 7'h20;
      {cmd, dat, w, p, nb} = 36'h8;
      kind = srpr_pkg::SRPR_RD_FAST_SINGLE;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check_all();
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         rs = rnd();
         d = (i < 4) ? (i == 0 ? 8'h80 : i == 1 ? 8'h7f : i == 2 ? 8'h04 : 8'h00) : rs[7:0];
         c = (i % 3 == 2) ? 8'h65 : (i % 3 == 0) ? 8'hc0 : 8'h63;
         qe <= (i > 3) & rs[8] & rs[9];
         four <= (i > 3) & rs[10] & rs[11];
         rpres <= (i > 3) & rs[12];
         rdis <= rs[13];
         // Pass four writes a zero dummy field, so pin the dual I/O default there.
         kind <= (i == 3) ? srpr_pkg::SRPR_RD_DUAL_IO : srpr_pkg::srpr_read_kind_e'(rs[18:16]);
         if (c == 8'h65) p = d;
         else w = d;
         send(c, d, 4'h8);
         check_all();
      end
      $display("test writes done");
      send(8'h05, 8'h5a, 4'h8);
      check_all();
      send(8'hc0, 8'ha5, 4'h4);
      check_all();
      $display("test refusals done");
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      w = 8'h00;
      p = 8'h00;
      check_all();
      $display("test second reset done");
      close_out();
   end
endmodule
`default_nettype wire
